// file: isa_sub_swap_xor_table_exec_test.sv
// Testbench for the execution slice: AXI4-Lite master, ROM and a reference model.
// Assumes ssx_pkg, ssx_exec and ssx_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
bind ssx_exec ssx_chk #(.ROM_AW(ROM_AW)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rom_addr(rom_addr), .timer0_mode(timer0_mode));
module isa_sub_swap_xor_table_exec_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [10:0] rom_addr;
    logic [13:0] rom_data;
    logic [7:0] tmode;
    logic [7:0] m_w = 8'h00, m_tph = 8'h00, m_tdh = 8'h00, m_tm = 8'h00;
    logic m_c = 1'b0, m_hc = 1'b0, m_z = 1'b0;
    logic [7:0] m_f [64];
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h99E2C65A;
    ssx_exec #(.ROM_AW(11)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rom_addr(rom_addr), .rom_data(rom_data), .timer0_mode(tmode));
    ////////////////////////////////////////
    // Clock, and a ROM whose word mixes pointer and low address bits so a wrong split shows
    always #5 aclk = ~aclk;
    function automatic logic [13:0] rom_f(input logic [10:0] a);
        return {a[10:8] ^ 3'h5, a[2:0], a[7:0] ^ 8'hC3};
    endfunction
    assign rom_data = rom_f(rom_addr);
    ////////////////////////////////////////
    // Comparison and bus tasks; bready and rready rise only after the answer is seen
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        chk(32'(bresp), 32'(e));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] r;
        rd(a, v, r);
        chk(v, e);
        chk(32'(r), 32'(ssx_pkg::RESP_OKAY));
    endtask
    task automatic setr(input logic [7:0] a, input logic [7:0] v);
        wr(a, {24'h0, v}, 4'hF, ssx_pkg::RESP_OKAY);
    endtask
    // One command through the model, then every visible result compared
    task automatic cmd(input logic [3:0] op, input logic [7:0] i, input logic [5:0] fa, input logic d);
        logic [31:0] v;
        logic [1:0] r;
        logic [7:0] x;
        logic [13:0] q;
        wr(ssx_pkg::ADDR_CMD, {7'h00, d, 2'h0, fa, i, 4'h0, op}, 4'hF, ssx_pkg::RESP_OKAY);
        x = (op == 4'h3) ? {m_f[fa][3:0], m_f[fa][7:4]} : m_w ^ ((op == 4'h6) ? i : m_f[fa]);
        q = rom_f({m_tph[2:0], m_w});
        case (op)
            4'h1: begin
                x = i - m_w;
                m_c = (i >= m_w);
                m_hc = (i[3:0] >= m_w[3:0]);
                m_z = (x == 8'h00);
                m_w = x;
            end
            4'h2: begin
                chk(32'(rom_addr), 32'({m_tph[2:0], m_w}));
                m_w = q[7:0];
                m_tdh = {2'h0, q[13:8]};
            end
            4'h4: m_tm = m_w;
            4'h5: m_w = m_tm;
            default: begin
                if (op != 4'h3) m_z = (x == 8'h00);
                if (d && op != 4'h6) m_f[fa] = x;
                else m_w = x;
            end
        endcase
        do rd(ssx_pkg::ADDR_STATUS, v, r); while (v[3] !== 1'b0);
        chk(v, {29'h0, m_z, m_hc, m_c});
        rdc(ssx_pkg::ADDR_WORK, {24'h0, m_w});
        rdc(ssx_pkg::ADDR_TDH, {24'h0, m_tdh});
        rdc(ssx_pkg::ADDR_TMODE, {24'h0, m_tm});
        chk(32'(tmode), {24'h0, m_tm});
        if (fa < 6'h20) rdc(8'h80 + {1'b0, fa[4:0], 2'h0}, {24'h0, m_f[fa]});
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////
    // Main sequence: reset values, decode, worked examples, then random commands
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        for (int k = 0; k < 64; k++) m_f[k] = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 24; a += 4) rdc(8'(a), 32'h0);
        chk(32'(tmode), 32'h0);
        rd(8'h20, v, r);
        chk(v, 32'h0);
        chk(32'(r), 32'(ssx_pkg::RESP_SLVERR));
        wr(8'h20, 32'h000000FF, 4'hF, ssx_pkg::RESP_SLVERR);
        $display("Test reset and decode done");
        for (int k = 0; k < 3; k++) begin
            m_w = (k == 0) ? 8'h06 : 8'h05;
            setr(ssx_pkg::ADDR_WORK, m_w);
            cmd(4'h1, (k == 1) ? 8'h06 : 8'h05, 6'h00, 1'b0);
        end
        m_tph = 8'h02;
        setr(ssx_pkg::ADDR_TPH, m_tph);
        m_w = 8'h34;
        setr(ssx_pkg::ADDR_WORK, m_w);
        cmd(4'h2, 8'h00, 6'h00, 1'b0);
        m_tm = 8'h5A;
        setr(ssx_pkg::ADDR_TMODE, m_tm);
        cmd(4'h5, 8'h00, 6'h00, 1'b0);
        cmd(4'h6, 8'h5A, 6'h00, 1'b0);
        $display("Test worked examples done");
        // File registers 32..63 are not loaded over the bus; commands reach them as operands and destinations
        for (int k = 0; k < 32; k++) begin
            m_f[k] = 8'($random(seed));
            setr(8'h80 + 8'(k * 4), m_f[k]);
        end
        for (int k = 0; k < 70; k++) begin
            if (k % 3 == 0) begin
                m_w = 8'($random(seed));
                setr(ssx_pkg::ADDR_WORK, m_w);
                m_tph = {5'h00, 3'($random(seed))};
                setr(ssx_pkg::ADDR_TPH, m_tph);
            end
            cmd(4'(k % 7 + 1), 8'($random(seed)), 6'($random(seed)), 1'($random(seed)));
        end
        $display("Test random commands done");
        test_done();
    end
    // Watchdog: the run needs about 2000 cycles, so 40000 means a hang
    initial begin
        #400000;
        n_errors++;
        test_done();
    end
endmodule // isa_sub_swap_xor_table_exec_test
`default_nettype wire

// file: ssx_exec.sv
// Execution slice: immediate subtract, nibble exchange, xor, ROM table read, timer-0 mode moves.
// Assumes an AXI4-Lite master on aclk and an asynchronous program ROM whose word is valid in the same cycle as rom_addr.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssx_exec #(
    parameter int ROM_AW = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ROM_AW-1:0] rom_addr,
    input wire logic [13:0] rom_data,
    output logic [7:0] timer0_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding used by both write and read paths
    // Nine bits, so the end of the window does not wrap to zero
    function automatic logic is_file(input logic [7:0] a);
        is_file = ({1'b0, a} >= {1'b0, ssx_pkg::ADDR_FILE})
            && ({1'b0, a} < {1'b0, ssx_pkg::ADDR_FILE} + {1'b0, ssx_pkg::FILE_SPAN});
    endfunction

    function automatic logic is_known(input logic [7:0] a);
        is_known = is_file(a) || a == ssx_pkg::ADDR_CMD || a == ssx_pkg::ADDR_WORK
            || a == ssx_pkg::ADDR_STATUS || a == ssx_pkg::ADDR_TPH
            || a == ssx_pkg::ADDR_TDH || a == ssx_pkg::ADDR_TMODE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] file_ff [64];
    logic [7:0] nxt_file [64];
    logic [7:0] work_ff, nxt_work;
    logic [7:0] tph_ff, nxt_tph;
    logic [5:0] tdh_ff, nxt_tdh;
    logic [7:0] tmode_ff, nxt_tmode;
    logic c_ff, nxt_c, hc_ff, nxt_hc, z_ff, nxt_z;
    ssx_pkg::ssx_state_t state_ff, nxt_state;
    ssx_pkg::ssx_op_t op_ff, nxt_op;
    logic [7:0] imm_ff, nxt_imm;
    logic [5:0] faddr_ff, nxt_faddr;
    logic dir_ff, nxt_dir;
    logic [ROM_AW-1:0] rom_addr_ff, nxt_rom_addr;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
    logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;

    logic do_write;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic [7:0] result;

    assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic: result bit 8 set means a borrow happened
    assign diff = {1'b0, imm_ff} - {1'b0, work_ff};
    assign diff_lo = {1'b0, imm_ff[3:0]} - {1'b0, work_ff[3:0]};

    // Result for the file-register and immediate paths
    always_comb begin
        unique case (op_ff)
            ssx_pkg::SSX_OP_NIBBLE_EXCHANGE: result = {file_ff[faddr_ff][3:0], file_ff[faddr_ff][7:4]};
            ssx_pkg::SSX_OP_XOR_FILE_REG: result = work_ff ^ file_ff[faddr_ff];
            ssx_pkg::SSX_OP_XOR_IMMEDIATE: result = work_ff ^ imm_ff;
            default: result = diff[7:0];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution and register writes; a command write while busy is dropped
    always_comb begin
        nxt_file = file_ff;
        nxt_work = work_ff;
        nxt_tph = tph_ff;
        nxt_tdh = tdh_ff;
        nxt_tmode = tmode_ff;
        nxt_c = c_ff;
        nxt_hc = hc_ff;
        nxt_z = z_ff;
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_imm = imm_ff;
        nxt_faddr = faddr_ff;
        nxt_dir = dir_ff;
        nxt_rom_addr = rom_addr_ff;
        unique case (state_ff)
            ssx_pkg::SSX_ST_IDLE: begin
                if (do_write && awaddr_ff == ssx_pkg::ADDR_CMD && wstrb_ff == 4'hF) begin
                    nxt_op = ssx_pkg::ssx_op_t'(wdata_ff[ssx_pkg::CMD_OP_LSB +: 4]);
                    nxt_imm = wdata_ff[ssx_pkg::CMD_IMM_LSB +: 8];
                    nxt_faddr = wdata_ff[ssx_pkg::CMD_FADDR_LSB +: 6];
                    nxt_dir = wdata_ff[ssx_pkg::CMD_DIR_BIT];
                    nxt_state = ssx_pkg::SSX_ST_EXEC;
                end else if (do_write && wstrb_ff[0]) begin
                    if (awaddr_ff == ssx_pkg::ADDR_WORK) nxt_work = wdata_ff[7:0];
                    if (awaddr_ff == ssx_pkg::ADDR_TPH) nxt_tph = wdata_ff[7:0];
                    if (awaddr_ff == ssx_pkg::ADDR_TMODE) nxt_tmode = wdata_ff[7:0];
                    if (awaddr_ff == ssx_pkg::ADDR_STATUS) begin
                        nxt_c = wdata_ff[ssx_pkg::ST_C];
                        nxt_hc = wdata_ff[ssx_pkg::ST_HC];
                        nxt_z = wdata_ff[ssx_pkg::ST_Z];
                    end
                    if (is_file(awaddr_ff)) nxt_file[awaddr_ff[7:2] - 6'h20] = wdata_ff[7:0];
                end
            end
            ssx_pkg::SSX_ST_EXEC: begin
                nxt_state = ssx_pkg::SSX_ST_IDLE;
                unique case (op_ff)
                    ssx_pkg::SSX_OP_IMM_MINUS_WORK_REG: begin
                        nxt_work = diff[7:0];
                        nxt_c = diff[8] == 1'b0;
                        nxt_hc = diff_lo[4] == 1'b0;
                        nxt_z = diff[7:0] == 8'h00;
                    end
                    ssx_pkg::SSX_OP_ROM_TABLE_READ: begin
                        nxt_rom_addr = ROM_AW'({tph_ff[2:0], work_ff});
                        nxt_state = ssx_pkg::SSX_ST_ROM;
                    end
                    ssx_pkg::SSX_OP_NIBBLE_EXCHANGE, ssx_pkg::SSX_OP_XOR_FILE_REG: begin
                        if (dir_ff) nxt_file[faddr_ff] = result;
                        else nxt_work = result;
                        if (op_ff == ssx_pkg::SSX_OP_XOR_FILE_REG) nxt_z = result == 8'h00;
                    end
                    ssx_pkg::SSX_OP_XOR_IMMEDIATE: begin
                        nxt_work = result;
                        nxt_z = result == 8'h00;
                    end
                    ssx_pkg::SSX_OP_TIMER0_MODE_LOAD: nxt_tmode = work_ff;
                    ssx_pkg::SSX_OP_TIMER0_MODE_READBACK: nxt_work = tmode_ff;
                    default: nxt_state = ssx_pkg::SSX_ST_IDLE;
                endcase
            end
            ssx_pkg::SSX_ST_ROM: begin
                // Second cycle: ROM word has arrived, no flags touched
                nxt_work = rom_data[7:0];
                nxt_tdh = rom_data[13:8];
                nxt_state = ssx_pkg::SSX_ST_IDLE;
            end
            default: nxt_state = ssx_pkg::SSX_ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 64; i++) file_ff[i] <= ssx_pkg::RST_BYTE;
            work_ff <= ssx_pkg::RST_BYTE;
            tph_ff <= ssx_pkg::RST_BYTE;
            tdh_ff <= 6'h00;
            tmode_ff <= ssx_pkg::RST_BYTE;
            c_ff <= 1'b0;
            hc_ff <= 1'b0;
            z_ff <= 1'b0;
            state_ff <= ssx_pkg::SSX_ST_IDLE;
            op_ff <= ssx_pkg::SSX_OP_NONE;
            imm_ff <= ssx_pkg::RST_BYTE;
            faddr_ff <= 6'h00;
            dir_ff <= 1'b0;
            rom_addr_ff <= '0;
        end else begin
            file_ff <= nxt_file;
            work_ff <= nxt_work;
            tph_ff <= nxt_tph;
            tdh_ff <= nxt_tdh;
            tmode_ff <= nxt_tmode;
            c_ff <= nxt_c;
            hc_ff <= nxt_hc;
            z_ff <= nxt_z;
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            imm_ff <= nxt_imm;
            faddr_ff <= nxt_faddr;
            dir_ff <= nxt_dir;
            rom_addr_ff <= nxt_rom_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI write channel: address and data are latched independently
    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_w_have = w_have_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_have = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_have = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = is_known(awaddr_ff) ? ssx_pkg::RESP_OKAY : ssx_pkg::RESP_SLVERR;
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
        end
        if (bvalid_ff && s_axi_bready) nxt_bvalid = 1'b0;
        // Ready only while nothing is held, so one write at a time
        nxt_awready = !nxt_aw_have && !nxt_bvalid && !awready_ff;
        nxt_wready = !nxt_w_have && !nxt_bvalid && !wready_ff;
        if (awready_ff && !s_axi_awvalid) nxt_awready = 1'b1;
        if (wready_ff && !s_axi_wvalid) nxt_wready = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ssx_pkg::RESP_OKAY;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff <= nxt_w_have;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read channel: one-cycle answer after the address is taken
    always_comb begin
        nxt_arready = !rvalid_ff && !arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = is_known(s_axi_araddr) ? ssx_pkg::RESP_OKAY : ssx_pkg::RESP_SLVERR;
            nxt_rdata = 32'h00000000;
            if (is_file(s_axi_araddr)) nxt_rdata[7:0] = file_ff[s_axi_araddr[7:2] - 6'h20];
            unique case (s_axi_araddr)
                ssx_pkg::ADDR_WORK: nxt_rdata[7:0] = work_ff;
                ssx_pkg::ADDR_STATUS: nxt_rdata[3:0] = {state_ff != ssx_pkg::SSX_ST_IDLE, z_ff, hc_ff, c_ff};
                ssx_pkg::ADDR_TPH: nxt_rdata[7:0] = tph_ff;
                ssx_pkg::ADDR_TDH: nxt_rdata[5:0] = tdh_ff;
                ssx_pkg::ADDR_TMODE: nxt_rdata[7:0] = tmode_ff;
                default: nxt_rdata[31:8] = 24'h000000;
            endcase
        end else if (arready_ff) begin
            nxt_arready = 1'b1;
        end
        if (rvalid_ff && s_axi_rready) nxt_rvalid = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= ssx_pkg::RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rom_addr = rom_addr_ff;
    assign timer0_mode = tmode_ff;

endmodule // ssx_exec
`default_nettype wire

// file: ssx_exec_assertions.sv
// Checker for the execution slice: bus handshakes, read data widths and result timing.
// Assumes a bind to ssx_exec; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ssx_chk #(
    parameter int ROM_AW = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic [7:0] timer0_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // Address of the read in flight, so read data can be tied to its register
    logic [7:0] rd_addr_ff;
    logic [7:0] nxt_rd_addr;
    always_comb begin
        nxt_rd_addr = rd_addr_ff;
        if (s_axi_arvalid && s_axi_arready) nxt_rd_addr = s_axi_araddr;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) rd_addr_ff <= 8'h00;
        else rd_addr_ff <= nxt_rd_addr;
    end
    ////////////////////////////////////////
    // Responses stand until taken; results move only in the wake of a write
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
    property p_tdh; s_axi_rvalid && rd_addr_ff == ssx_pkg::ADDR_TDH |-> s_axi_rdata[31:6] == 26'h0; endproperty
    a_tdh: assert property (p_tdh) else $error("table high data wider than six bits");
    property p_rresp; s_axi_rvalid && rd_addr_ff < 8'h18 && rd_addr_ff[1:0] == 2'h0
        |-> s_axi_rresp == ssx_pkg::RESP_OKAY; endproperty
    a_rresp: assert property (p_rresp) else $error("mapped read refused");
    // The reset guard keeps a release edge from counting as a change
    property p_tmode; $changed(timer0_mode) && $past(aresetn) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
        || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2); endproperty
    a_tmode: assert property (p_tmode) else $error("timer mode moved with no write");
    property p_rom; $changed(rom_addr) && $past(aresetn) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
        || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2); endproperty
    a_rom: assert property (p_rom) else $error("rom address moved with no write");
endmodule // ssx_chk
`default_nettype wire

// file: ssx_pkg.sv
// Package for the sub/swap/xor/table execution slice.
// Assumes an 8-bit datapath, 64 file registers and an 11-bit ROM address.
package ssx_pkg;
    // Register byte addresses on the AXI4-Lite slave
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_WORK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TPH = 8'h0C;
    localparam logic [7:0] ADDR_TDH = 8'h10;
    localparam logic [7:0] ADDR_TMODE = 8'h14;
    localparam logic [7:0] ADDR_FILE = 8'h80;
    localparam logic [7:0] FILE_SPAN = 8'h80;
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_IMM_LSB = 8;
    localparam int CMD_FADDR_LSB = 16;
    localparam int CMD_DIR_BIT = 24;
    // Status register fields
    localparam int ST_C = 0;
    localparam int ST_HC = 1;
    localparam int ST_Z = 2;
    localparam int ST_BUSY = 3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TABLE = 2'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Operation codes
    typedef enum logic [3:0] {
        SSX_OP_NONE = 4'h0,
        SSX_OP_IMM_MINUS_WORK_REG = 4'h1,
        SSX_OP_ROM_TABLE_READ = 4'h2,
        SSX_OP_NIBBLE_EXCHANGE = 4'h3,
        SSX_OP_TIMER0_MODE_LOAD = 4'h4,
        SSX_OP_TIMER0_MODE_READBACK = 4'h5,
        SSX_OP_XOR_IMMEDIATE = 4'h6,
        SSX_OP_XOR_FILE_REG = 4'h7
    } ssx_op_t;
    // Execution state
    typedef enum logic [1:0] {
        SSX_ST_IDLE = 2'h0,
        SSX_ST_EXEC = 2'h1,
        SSX_ST_ROM = 2'h3
    } ssx_state_t;
endpackage
